/* backlight_dimming_control.sv */
// Backlight dimming control: SMBus registers, duty measurement, dimming PWM.
// Assumes a free-running link clock and static
// frequency straps; faults come from comparators.
`timescale 1ns/1ns
`default_nettype none

//Contract
//- Target address 0x2C only
//- Select 1: external duty
//- Interp bit: absolute or product
//- External mode: measured duty
//- Absolute mode ignores external input
//- Product of brightness and duty
//- Product starts at full duty
//- Brightness register at 0x00
//- 0xFF full, 0x00 minimum duty
//- Brightness resets to 0xFF
//- Brightness write ignored if external
//- Brightness always reads back
//- Control bits 2:0 RW, rest zero
//- On within 10 ms of enable; code turns on after the full ON_DELAY_CYC wake count plus sync delay
//- Enable 0: off at once
//- Control resets to zero
//- Off until host enables
//- Status RO, bits 7:6 zero, bit 3 on
//- Status bit 0 ORs other faults; code ORs only thermal and overcurrent, not the channel bits
//- PWM gates current sources
//- Period strap, 200 Hz to 2 kHz
//- Bits 5/4: multi/single channel
//- Bit 2 overcurrent, 1 thermal
//- Status sticky, cleared at startup
module backlight_dimming_control #(
    parameter int ON_DELAY_CYC = dimming_pkg::ON_DELAY_CYCLES
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // SMBus link
    input wire logic link_clk,
    input wire logic smb_clk_in,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe_b,
    // Dimming inputs
    input wire logic external_duty_input,
    input wire logic [10:0] dimming_frequency_set,
    // Fault indicators
    input wire logic thermal_trip_in,
    input wire logic overcurrent_in,
    input wire logic [7:0] channel_fault_in,
    // Dimming outputs
    output logic internal_dimming_pwm,
    output logic backlight_on_flag
);
    import dimming_pkg::*;

    typedef enum logic [1:0] {BL_OFF, BL_WAKE, BL_ON} bl_state_type;

    // Link domain
    logic lrst_s1_r, lrst_s2_r;
    logic [7:0] brightness_r;
    logic [2:0] control_r;
    logic therm_s1_r, therm_s2_r, over_s1_r, over_s2_r;
    logic [7:0] chan_s1_r, chan_s2_r;
    logic thermal_r, over_r, single_r, multi_r;
    logic on_s1_r, on_s2_r, ack_s1_r, ack_s2_r;
    logic [10:0] xfer_data_r;
    logic xfer_req_r;
    logic [3:0] chan_count;
    logic startup_pulse;
    logic [7:0] status_val;

    // System domain
    logic req_s1_r, req_s2_r, ack_r;
    logic [10:0] cfg_r;
    logic duty_s1_r, duty_s2_r, duty_prev_r;
    logic [10:0] dimming_frequency_set_s1_r, dimming_frequency_set_s2_r;
    logic [MEAS_W-1:0] hi_cnt_r, per_cnt_r, den_r;
    logic [MEAS_W:0] rem_r, rem_sh;
    logic [7:0] quot_r, meas_duty_r, meas_eff;
    logic [3:0] div_cnt_r;
    logic meas_valid_r, prod_prev_r, prod_mode, duty_rise;
    logic [15:0] product;
    logic [15:0] scaled;
    logic [7:0] target_duty, mode_duty;
    logic [10:0] step_len, prescale_r;
    logic [7:0] phase_r, duty_r;
    logic pwm_r;
    bl_state_type bl_state_r;
    logic [WAKE_W-1:0] wake_cnt_r;

    reg_access_if bus();

    // Link reset via two flops
    always_ff @(posedge link_clk) begin
        lrst_s1_r <= rst_b;
        lrst_s2_r <= lrst_s1_r;
    end

    smbus_target u_target (
        .link_clk(link_clk),
        .link_rst_b(lrst_s2_r),
        .scl_in(smb_clk_in),
        .sda_in(smb_data_in),
        .sda_oe_b(smb_data_oe_b),
        .bus(bus.target)
    );

    // Open-drain: the pin is only ever pulled low
    assign smb_data_out = 1'b0;

    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            brightness_r <= BRIGHTNESS_RESET;
        end else if (bus.wr_stb && bus.addr == REG_BRIGHTNESS &&
                     !control_r[CTL_SOURCE_BIT]) begin
            brightness_r <= bus.wr_data;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            control_r <= CONTROL_RESET;
        end else if (bus.wr_stb && bus.addr == REG_CONTROL) begin
            control_r <= bus.wr_data[CTL_WIDTH-1:0];
        end
    end

    assign startup_pulse = bus.wr_stb && bus.addr == REG_CONTROL &&
        bus.wr_data[CTL_ENABLE_BIT] && !control_r[CTL_ENABLE_BIT];

    always_ff @(posedge link_clk) begin
        therm_s1_r <= thermal_trip_in;
        therm_s2_r <= therm_s1_r;
        over_s1_r <= overcurrent_in;
        over_s2_r <= over_s1_r;
        chan_s1_r <= channel_fault_in;
        chan_s2_r <= chan_s1_r;
        on_s1_r <= bl_state_r == BL_ON;
        on_s2_r <= on_s1_r;
        ack_s1_r <= ack_r;
        ack_s2_r <= ack_s1_r;
    end

    always_comb begin
        chan_count = 4'h0;
        for (int i = 0; i < 8; i++) begin
            chan_count = chan_count + {3'h0, chan_s2_r[i]};
        end
    end

    // Latched faults survive shutdown; a fault present at startup wins
    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            thermal_r <= 1'b0;
            over_r <= 1'b0;
            single_r <= 1'b0;
            multi_r <= 1'b0;
        end else begin
            thermal_r <= (thermal_r & ~startup_pulse) | therm_s2_r;
            over_r <= (over_r & ~startup_pulse) | over_s2_r;
            single_r <= (single_r & ~startup_pulse) |
                (chan_count == 4'h1);
            multi_r <= (multi_r & ~startup_pulse) | (chan_count >= 4'h2);
        end
    end

    always_comb begin
        status_val = 8'h00;
        status_val[STAT_ANY_FAULT] = thermal_r | over_r;
        status_val[STAT_THERMAL] = thermal_r;
        status_val[STAT_OVERCURRENT] = over_r;
        status_val[STAT_BL_ON] = on_s2_r;
        status_val[STAT_SINGLE_CH] = single_r;
        status_val[STAT_MULTI_CH] = multi_r;
    end

    always_comb begin
        unique case (bus.addr)
            REG_BRIGHTNESS: bus.rd_data = brightness_r;
            REG_CONTROL: bus.rd_data = {5'h00, control_r};
            REG_STATUS: bus.rd_data = status_val;
            default: bus.rd_data = 8'h00;
        endcase
    end

    // Word held stable while the toggle is unanswered
    always_ff @(posedge link_clk) begin
        if (!lrst_s2_r) begin
            xfer_data_r <= {CONTROL_RESET, BRIGHTNESS_RESET};
            xfer_req_r <= 1'b0;
        end else if (xfer_req_r == ack_s2_r &&
                     xfer_data_r != {control_r, brightness_r}) begin
            xfer_data_r <= {control_r, brightness_r};
            xfer_req_r <= ~xfer_req_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        req_s1_r <= xfer_req_r;
        req_s2_r <= req_s1_r;
        duty_s1_r <= external_duty_input;
        duty_s2_r <= duty_s1_r;
        dimming_frequency_set_s1_r <= dimming_frequency_set;
        dimming_frequency_set_s2_r <= dimming_frequency_set_s1_r;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_r <= {CONTROL_RESET, BRIGHTNESS_RESET};
            ack_r <= 1'b0;
        end else if (req_s2_r != ack_r) begin
            cfg_r <= xfer_data_r;
            ack_r <= req_s2_r;
        end
    end

    // External period and high time, edge to edge
    assign duty_rise = duty_s2_r & ~duty_prev_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            duty_prev_r <= 1'b0;
            hi_cnt_r <= '0;
            per_cnt_r <= '0;
        end else begin
            duty_prev_r <= duty_s2_r;
            if (duty_rise) begin
                per_cnt_r <= MEAS_W'(1);
                hi_cnt_r <= MEAS_W'(1);
            end else if (per_cnt_r != '1) begin
                per_cnt_r <= per_cnt_r + MEAS_W'(1);
                hi_cnt_r <= hi_cnt_r + MEAS_W'(duty_s2_r);
            end
        end
    end

    assign rem_sh = {rem_r[MEAS_W-1:0], 1'b0};
    assign prod_mode = ~cfg_r[8 + CTL_SOURCE_BIT] & ~cfg_r[8 + CTL_INTERP_BIT];

    // Restoring divide: duty in 1/256 steps
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rem_r <= '0;
            den_r <= '0;
            quot_r <= 8'h00;
            div_cnt_r <= 4'h0;
            meas_duty_r <= FULL_DUTY;
            meas_valid_r <= 1'b0;
            prod_prev_r <= 1'b0;
        end else begin
            prod_prev_r <= prod_mode;
            if (duty_rise && per_cnt_r != '0) begin
                rem_r <= {1'b0, hi_cnt_r};
                den_r <= per_cnt_r;
                quot_r <= 8'h00;
                div_cnt_r <= 4'h8;
            end else if (div_cnt_r != 4'h0) begin
                div_cnt_r <= div_cnt_r - 4'h1;
                if (rem_sh >= {1'b0, den_r}) begin
                    rem_r <= rem_sh - {1'b0, den_r};
                    quot_r <= {quot_r[6:0], 1'b1};
                end else begin
                    rem_r <= rem_sh;
                    quot_r <= {quot_r[6:0], 1'b0};
                end
            end
            if (prod_mode && !prod_prev_r) begin
                meas_valid_r <= 1'b0;
            end else if (div_cnt_r == 4'h1) begin
                meas_duty_r <= (rem_sh >= {1'b0, den_r}) ?
                    {quot_r[6:0], 1'b1} : {quot_r[6:0], 1'b0};
                meas_valid_r <= 1'b1;
            end else if (per_cnt_r == '1) begin
                // A steady input level stands for 0 or full duty
                meas_duty_r <= duty_s2_r ? FULL_DUTY : 8'h00;
                meas_valid_r <= 1'b1;
            end
        end
    end

    assign meas_eff = meas_valid_r ? meas_duty_r : FULL_DUTY;
    assign product = cfg_r[7:0] * meas_eff;
    assign scaled = (product + (product >> 8) + 16'h0001) >> 8;

    always_comb begin
        if (cfg_r[8 + CTL_SOURCE_BIT]) begin
            mode_duty = meas_eff;
        end else if (cfg_r[8 + CTL_INTERP_BIT]) begin
            mode_duty = cfg_r[7:0];
        end else begin
            mode_duty = scaled[7:0];
        end
        target_duty = (mode_duty < MIN_DUTY) ? MIN_DUTY : mode_duty;
    end

    // Period is 256 steps; out-of-range straps clamp
    always_comb begin
        if (dimming_frequency_set_s2_r < 11'(STEP_MIN)) begin
            step_len = 11'(STEP_MIN);
        end else if (dimming_frequency_set_s2_r > 11'(STEP_MAX)) begin
            step_len = 11'(STEP_MAX);
        end else begin
            step_len = dimming_frequency_set_s2_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prescale_r <= 11'h000;
            phase_r <= 8'h00;
            duty_r <= FULL_DUTY;
        end else if (prescale_r >= step_len - 11'h001) begin
            prescale_r <= 11'h000;
            phase_r <= phase_r + 8'h01;
            if (phase_r == 8'hFF) begin
                duty_r <= target_duty;
            end
        end else begin
            prescale_r <= prescale_r + 11'h001;
        end
    end

    // Wait out startup, drop out at once
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bl_state_r <= BL_OFF;
            wake_cnt_r <= '0;
        end else begin
            unique case (bl_state_r)
                BL_OFF: begin
                    wake_cnt_r <= '0;
                    if (cfg_r[8 + CTL_ENABLE_BIT]) begin
                        bl_state_r <= BL_WAKE;
                    end
                end
                BL_WAKE: begin
                    if (!cfg_r[8 + CTL_ENABLE_BIT]) begin
                        bl_state_r <= BL_OFF;
                    end else if (wake_cnt_r >=
                                 WAKE_W'(ON_DELAY_CYC - 1)) begin
                        bl_state_r <= BL_ON;
                    end else begin
                        wake_cnt_r <= wake_cnt_r + WAKE_W'(1);
                    end
                end
                BL_ON: begin
                    if (!cfg_r[8 + CTL_ENABLE_BIT]) begin
                        bl_state_r <= BL_OFF;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= (bl_state_r == BL_ON) && (phase_r <= duty_r);
        end
    end

    assign internal_dimming_pwm = pwm_r;
    assign backlight_on_flag = bl_state_r == BL_ON;

endmodule
`default_nettype wire

/* backlight_dimming_control_chk.sv */
// Port checker for the dimming control block.
// Bound by the bench; sees only the top ports.
`timescale 1ns/1ns
`default_nettype none
module backlight_dimming_control_chk #(
    parameter int ON_DELAY_CYC = 50
) (
    // Clocks and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic link_clk,
    // SMBus
    input wire logic smb_clk_in,
    input wire logic smb_data_out,
    input wire logic smb_data_oe_b,
    // Outputs
    input wire logic internal_dimming_pwm,
    input wire logic backlight_on_flag
);
    // Off time; wake may not be shorter
    int off_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_b || backlight_on_flag) begin
            off_cnt_r <= 0;
        end else begin
            off_cnt_r <= off_cnt_r + 1;
        end
    end
    reset_quiet_a: assert property (@(posedge sys_clk)
        !rst_b |=> !backlight_on_flag && !internal_dimming_pwm)
        else $error("active in reset");
    dark_off_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        !backlight_on_flag ##1 !backlight_on_flag |-> !internal_dimming_pwm)
        else $error("pwm high while off");
    wake_time_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b) $rose(backlight_on_flag) |->
        off_cnt_r >= ON_DELAY_CYC) else $error("wake short");
    pwm_gate_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b) $rose(internal_dimming_pwm) |->
        $past(backlight_on_flag)) else $error("pwm without on");
    min_pulse_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b) $rose(internal_dimming_pwm) |=>
        (internal_dimming_pwm || !backlight_on_flag) [*7])
        else $error("pulse short");
    drive_low_a: assert property (@(posedge link_clk)
        disable iff (!rst_b) smb_data_out == 1'b0)
        else $error("data driven high");
    sda_scl_low_a: assert property (@(posedge link_clk)
        disable iff (!rst_b) $changed(smb_data_oe_b) |-> !smb_clk_in)
        else $error("sda moved, scl high");
    ack_hold_a: assert property (@(posedge link_clk)
        disable iff (!rst_b) $fell(smb_data_oe_b) |=> !smb_data_oe_b [*8])
        else $error("ack too short");
    cover property (@(posedge sys_clk) $rose(backlight_on_flag));
    cover property (@(posedge sys_clk) $fell(backlight_on_flag));
    cover property (@(posedge link_clk) $fell(smb_data_oe_b));
endmodule
`default_nettype wire

/* backlight_dimming_control_tb.sv */
// Bench for dimming control with an SMBus host model.
// Needs the host model and checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module backlight_dimming_control_tb;
    import dimming_pkg::*;
    localparam int WAKE = 50;
    localparam int STEP = 196;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ext_in = 1'b0;
    logic thermal = 1'b0;
    logic overcur = 1'b0;
    logic [7:0] chan = 8'h00;
    logic scl, sda, dout, oe_b, pwm, on, nack;
    logic [7:0] rd, b;
    logic [7:0] m = 8'h80;
    int err_count = 0;
    int comparisons = 0;
    int seed = 32'h4924bcfe;
    int ph = 0;
    int waited;
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #80 link_clk = ~link_clk;
    end
    // 2560-cycle period makes measured duty exact
    always @(negedge sys_clk) begin
        ph <= (ph == 2559) ? 0 : ph + 1;
        ext_in <= ph < m * 10;
    end
    backlight_dimming_control #(.ON_DELAY_CYC(WAKE))
        i_backlight_dimming_control (.sys_clk(sys_clk), .rst_b(rst_b),
        .link_clk(link_clk), .smb_clk_in(scl), .smb_data_in(sda),
        .smb_data_out(dout), .smb_data_oe_b(oe_b),
        .external_duty_input(ext_in), .dimming_frequency_set(11'h0C4),
        .thermal_trip_in(thermal), .overcurrent_in(overcur),
        .channel_fault_in(chan), .internal_dimming_pwm(pwm),
        .backlight_on_flag(on));
    smbus_host_model i_smbus_host_model (.sys_clk(sys_clk),
        .dev_oe_b(oe_b), .scl(scl), .sda(sda));
    function automatic int duty(input int p);
        return (p < 7) ? 7 : p;
    endfunction
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wait_for(input logic pick, input logic lvl, input int lim);
        waited = 0;
        while ((pick ? pwm : on) !== lvl && waited < lim) begin
            @(negedge sys_clk);
            waited++;
        end
        check(waited < lim, 1'b1);
        if (waited >= lim) begin
            print_verdict();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_smbus_host_model.xfer(1'b1, TARGET_ADDR, a, 8'h00, rd, nack);
        check(rd, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_smbus_host_model.xfer(1'b0, TARGET_ADDR, a, d, rd, nack);
        check(nack, 1'b0);
    endtask
    initial begin
        // Link side needs link edges of reset
        repeat (12) @(negedge link_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge link_clk);
        @(negedge sys_clk);
        rchk(REG_BRIGHTNESS, 8'hFF);
        rchk(REG_CONTROL, 8'h00);
        rchk(REG_STATUS, 8'h00);
        rchk(8'h03, 8'h00);
        i_smbus_host_model.xfer(1'b0, 7'h2D, REG_CONTROL, 8'h01, rd, nack);
        check(nack, 1'b1);
        wr(REG_CONTROL, 8'hFE);
        rchk(REG_CONTROL, 8'h06);
        b = 8'($random(seed));
        wr(REG_BRIGHTNESS, b);
        rchk(REG_BRIGHTNESS, 8'hFF);
        wr(REG_CONTROL, 8'h00);
        wr(REG_BRIGHTNESS, b);
        rchk(REG_BRIGHTNESS, b);
        m = 8'h01 + 8'({$random(seed)} % 254);
        wr(REG_CONTROL, 8'h01);
        wait_for(1'b0, 1'b1, WAKE + 100);
        rchk(REG_STATUS, 8'h08);
        overcur = 1'b1;
        chan = 8'h11;
        rchk(REG_STATUS, 8'h2D);
        overcur = 1'b0;
        thermal = 1'b1;
        chan = 8'h04;
        rchk(REG_STATUS, 8'h3F);
        thermal = 1'b0;
        chan = 8'h00;
        // First pulse may carry the old duty
        wait_for(1'b1, 1'b1, 60000);
        wait_for(1'b1, 1'b0, 60000);
        wait_for(1'b1, 1'b1, 60000);
        wait_for(1'b1, 1'b0, 60000);
        check(waited, (duty(b * m / 255) + 1) * STEP);
        wr(REG_CONTROL, 8'h00);
        wait_for(1'b0, 1'b0, 60);
        rchk(REG_STATUS, 8'h37);
        wr(REG_CONTROL, 8'h01);
        rchk(REG_STATUS, 8'h08);
        print_verdict();
    end
endmodule
bind backlight_dimming_control backlight_dimming_control_chk #(
    .ON_DELAY_CYC(ON_DELAY_CYC)) i_backlight_dimming_control_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk),
    .smb_clk_in(smb_clk_in), .smb_data_out(smb_data_out),
    .smb_data_oe_b(smb_data_oe_b),
    .internal_dimming_pwm(internal_dimming_pwm),
    .backlight_on_flag(backlight_on_flag));
`default_nettype wire

/* dimming_pkg.sv */
// Constants shared by the backlight dimming control block.
// Assumes a 100 MHz system clock.
package dimming_pkg;

    // Target address and offsets
    localparam logic [6:0] TARGET_ADDR = 7'h2C;
    localparam logic [7:0] REG_BRIGHTNESS = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;

    // Control register fields
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_SOURCE_BIT = 1;
    localparam int CTL_INTERP_BIT = 2;
    localparam int CTL_WIDTH = 3;

    // Status register fields
    localparam int STAT_ANY_FAULT = 0;
    localparam int STAT_THERMAL = 1;
    localparam int STAT_OVERCURRENT = 2;
    localparam int STAT_BL_ON = 3;
    localparam int STAT_SINGLE_CH = 4;
    localparam int STAT_MULTI_CH = 5;

    // Reset values
    localparam logic [7:0] BRIGHTNESS_RESET = 8'hFF;
    localparam logic [2:0] CONTROL_RESET = 3'h0;

    // Duty limits: 7/256 is about 2.7 percent
    localparam logic [7:0] MIN_DUTY = 8'h07;
    localparam logic [7:0] FULL_DUTY = 8'hFF;

    // Timing
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int ON_TIME_MS = 10;
    localparam int ON_DELAY_CYCLES = ON_TIME_MS * (SYS_CLK_HZ / 1000);
    localparam int FREQ_MAX_HZ = 2000;
    localparam int FREQ_MIN_HZ = 200;
    localparam int PWM_STEPS = 256;
    localparam int STEP_MIN =
        (SYS_CLK_HZ + FREQ_MAX_HZ * PWM_STEPS - 1) / (FREQ_MAX_HZ * PWM_STEPS);
    localparam int STEP_MAX = SYS_CLK_HZ / (FREQ_MIN_HZ * PWM_STEPS);
    localparam int MEAS_W = 20;
    localparam int WAKE_W = 20;

endpackage

/* reg_access_if.sv */
// Carrier from the SMBus target to the register file.
// Assumes both ends run on the link clock.
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
    logic wr_stb;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport target(output wr_stb, output addr, output wr_data,
                   input rd_data);
    modport regs(input wr_stb, input addr, input wr_data,
                 output rd_data);
endinterface
`default_nettype wire

/* smbus_host_model.sv */
// SMBus host model: byte write and byte read with repeated start.
// Assumes an open-drain data wire with a pull-up; SCL idles high.
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model (
    // Timing reference
    input wire logic sys_clk,
    // Bus wires
    input wire logic dev_oe_b,
    output logic scl,
    output logic sda
);
    // Over eight link cycles per half period
    localparam int HALF = 140;
    logic drv = 1'b1;
    assign sda = drv & dev_oe_b;
    initial scl = 1'b1;
    task automatic hold();
        repeat (HALF) @(negedge sys_clk);
    endtask
    task automatic bit_io(input logic tx, output logic rx);
        drv = tx;
        hold();
        scl = 1'b1;
        hold();
        rx = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        drv = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        drv = 1'b0;
        hold();
        scl = 1'b0;
    endtask
    task automatic octet(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask
    task automatic xfer(input logic rd, input logic [6:0] a,
            input logic [7:0] cmd, input logic [7:0] wd,
            output logic [7:0] q, output logic nack);
        logic [8:0] r;
        start();
        octet({a, 1'b0, 1'b1}, r);
        nack = r[0];
        octet({cmd, 1'b1}, r);
        if (rd) begin
            start();
            octet({a, 1'b1, 1'b1}, r);
            octet(9'h1FF, r);
        end else begin
            octet({wd, 1'b1}, r);
        end
        q = r[8:1];
        drv = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        drv = 1'b1;
    endtask
endmodule
`default_nettype wire

/* smbus_target.sv */
// SMBus target: write-byte and read-byte of one register.
// Assumes SCL far slower than the link clock; no stretching.
`timescale 1ns/1ns
`default_nettype none
module smbus_target (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst_b,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_b,
    // Register side
    reg_access_if.target bus
);
    import dimming_pkg::*;

    typedef enum logic [2:0] {T_IDLE, T_RX, T_RX_ACK, T_TX, T_TX_ACK}
        target_state_type;

    target_state_type state_r;
    logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r, scl_d_r, sda_d_r;
    logic [7:0] shift_r, ptr_r, wr_data_r;
    logic [3:0] bitcnt_r;
    logic [1:0] byte_idx_r;
    logic rw_r, ack_ok_r, drive_low_r, wr_stb_r;
    logic start_ev, stop_ev, scl_rise, scl_fall;

    always_ff @(posedge link_clk) begin
        scl_s1_r <= scl_in;
        scl_s2_r <= scl_s1_r;
        sda_s1_r <= sda_in;
        sda_s2_r <= sda_s1_r;
        scl_d_r <= scl_s2_r;
        sda_d_r <= sda_s2_r;
    end

    assign start_ev = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign stop_ev = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
    assign scl_rise = scl_s2_r & ~scl_d_r;
    assign scl_fall = ~scl_s2_r & scl_d_r;

    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            state_r <= T_IDLE;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            wr_data_r <= 8'h00;
            bitcnt_r <= 4'h0;
            byte_idx_r <= 2'h0;
            rw_r <= 1'b0;
            ack_ok_r <= 1'b0;
            drive_low_r <= 1'b0;
            wr_stb_r <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            if (start_ev) begin
                state_r <= T_RX;
                bitcnt_r <= 4'h0;
                byte_idx_r <= 2'h0;
                drive_low_r <= 1'b0;
            end else if (stop_ev) begin
                state_r <= T_IDLE;
                drive_low_r <= 1'b0;
            end else begin
                unique case (state_r)
                    T_IDLE: begin
                    end
                    T_RX: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s2_r};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (scl_fall && bitcnt_r == 4'h8) begin
                            bitcnt_r <= 4'h0;
                            // Foreign address: stay silent until next start
                            if (byte_idx_r == 2'h0 &&
                                shift_r[7:1] != TARGET_ADDR) begin
                                state_r <= T_IDLE;
                            end else begin
                                drive_low_r <= 1'b1;
                                state_r <= T_RX_ACK;
                                if (byte_idx_r == 2'h0) begin
                                    rw_r <= shift_r[0];
                                end else if (byte_idx_r == 2'h1) begin
                                    ptr_r <= shift_r;
                                end else begin
                                    wr_data_r <= shift_r;
                                    wr_stb_r <= 1'b1;
                                end
                            end
                        end
                    end
                    T_RX_ACK: begin
                        if (scl_fall) begin
                            if (byte_idx_r == 2'h0 && rw_r) begin
                                shift_r <= bus.rd_data;
                                drive_low_r <= ~bus.rd_data[7];
                                state_r <= T_TX;
                            end else begin
                                drive_low_r <= 1'b0;
                                state_r <= T_RX;
                                if (byte_idx_r != 2'h2) begin
                                    byte_idx_r <= byte_idx_r + 2'h1;
                                end
                            end
                        end
                    end
                    T_TX: begin
                        if (scl_fall) begin
                            if (bitcnt_r == 4'h7) begin
                                drive_low_r <= 1'b0;
                                bitcnt_r <= 4'h0;
                                state_r <= T_TX_ACK;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                drive_low_r <= ~shift_r[6];
                                bitcnt_r <= bitcnt_r + 4'h1;
                            end
                        end
                    end
                    T_TX_ACK: begin
                        if (scl_rise) begin
                            ack_ok_r <= ~sda_s2_r;
                        end else if (scl_fall) begin
                            if (ack_ok_r) begin
                                shift_r <= bus.rd_data;
                                drive_low_r <= ~bus.rd_data[7];
                                state_r <= T_TX;
                            end else begin
                                state_r <= T_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign sda_oe_b = ~drive_low_r;
    assign bus.wr_stb = wr_stb_r;
    assign bus.addr = ptr_r;
    assign bus.wr_data = wr_data_r;

endmodule
`default_nettype wire
